// file: core/atlc_pkg.sv
// What this block does
// - Five stages: RF 20,20,10 then IF 20,10
// - Stages on or off, attenuation sums
// - Mixer above 1000 means automatic, -20 dBm
// - Automatic mode hides mixer coercion warnings
// - Mixer above 0 dBm clamps, warns
// - Reference above 50 dBm clamps, warns
// - Mixer above reference becomes reference, warns
// - Mixer below reference minus 50 clamps, warns
// - Later coercion only when unrealisable
// - RF stages resolved before IF stages
// - RF difference is reference minus mixer
// - RF difference picks RF stage combination
// - IF value is 30 plus mixer
// - Negative IF value clamps to zero, warns outside automatic mode
// - IF value picks IF stage combination
// - Frequency below 15 MHz engages IF 10 dB
//
// Purpose: constants and carriers for the attenuator level control.
// Assumes: one clock domain, signed dBm levels, frequencies in kHz.
// Notes:   register offsets are byte addresses on the plain port.
`default_nettype none
package atlc_pkg;
    localparam int          ATLC_AW          = 8;
    localparam int          ATLC_DW          = 32;
    localparam int          ATLC_LW          = 18;

    localparam logic [7:0]  ATLC_OFS_REF     = 8'h00;
    localparam logic [7:0]  ATLC_OFS_MIX     = 8'h04;
    localparam logic [7:0]  ATLC_OFS_FREQ    = 8'h08;
    localparam logic [7:0]  ATLC_OFS_CTRL    = 8'h0C;
    localparam logic [7:0]  ATLC_OFS_STATUS  = 8'h10;
    localparam logic [7:0]  ATLC_OFS_LEVELS  = 8'h14;

    localparam int          ATLC_CTRL_APPLY  = 0;
    localparam int          ATLC_ST_BUSY     = 0;
    localparam int          ATLC_ST_AUTO     = 1;
    localparam int          ATLC_ST_LOWF     = 2;
    localparam int          ATLC_ST_ATT_LSB  = 3;
    localparam int          ATLC_ST_WARN_LSB = 8;

    localparam logic [15:0] ATLC_REF_RST     = 16'h0000;
    localparam logic [15:0] ATLC_MIX_RST     = 16'h0000;
    localparam logic [31:0] ATLC_FREQ_RST    = 32'h0000_0000;

    localparam logic signed [15:0] ATLC_AUTO_THRESH = 16'sh03E8;
    localparam logic signed [17:0] ATLC_AUTO_MIX    = 18'sh3_FFEC;
    localparam logic signed [17:0] ATLC_MIX_MAX     = 18'sh0_0000;
    localparam logic signed [17:0] ATLC_REF_MAX     = 18'sh0_0032;
    localparam logic signed [17:0] ATLC_WINDOW      = 18'sh0_0032;
    localparam logic signed [17:0] ATLC_IF_GAIN     = 18'sh0_001E;
    localparam int                 ATLC_STEP_DB     = 10;
    localparam int                 ATLC_RF_STEPS    = 5;
    localparam int                 ATLC_IF_STEPS    = 3;
    localparam logic [31:0]        ATLC_LOWF_KHZ    = 32'h0000_3A98;

    typedef struct packed {
        logic rf_20a;
        logic rf_20b;
        logic rf_10;
        logic if_20;
        logic if_10;
    } atlc_atten_t;

    typedef struct packed {
        logic mix_above_zero;
        logic ref_range;
        logic mix_window;
        logic if_below_nominal;
    } atlc_warn_t;

    typedef enum logic [1:0] {
        ATLC_IDLE   = 2'b00,
        ATLC_COERCE = 2'b01,
        ATLC_RF     = 2'b11,
        ATLC_IF     = 2'b10
    } atlc_state_t;
endpackage
`default_nettype wire

// file: core/atlc_step_sel.sv
// Purpose: rounds a signed dB value to a whole number of steps.
// Assumes: ties round upward; result clamps to 0..STEPS.
// Notes:   pure combinational, used for both RF and IF chains.
`default_nettype none
module atlc_step_sel
    import atlc_pkg::*;
#(
    parameter int W       = 18,
    parameter int STEPS   = 5,
    parameter int STEP_DB = 10,
    parameter int IW      = 3
) (
    input  wire logic signed [W-1:0] value,
    output logic             [IW-1:0] idx
);
    always_comb begin
        idx = '0;
        for (int k = 1; k <= STEPS; k++) begin
            if (value >= W'(k * STEP_DB - STEP_DB / 2)) begin
                idx = IW'(k);
            end
        end
    end
endmodule
`default_nettype wire

// file: core/atlc_level_ctrl.sv
// Purpose: turns reference and mixer requests into stage settings.
// Assumes: register port strobes one cycle long, never together.
// Notes:   apply while busy is ignored; outputs change only at commit, except IF 10 dB on a low-frequency write.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`default_nettype none
module atlc_level_ctrl
    import atlc_pkg::*;
#(
    parameter logic [31:0] LOWF_KHZ = ATLC_LOWF_KHZ
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic [ATLC_AW-1:0] reg_addr,
    input  wire logic [ATLC_DW-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [ATLC_DW-1:0] reg_rdata,
    output atlc_atten_t            atten,
    output atlc_warn_t             warn,
    output logic                   automatic_mixer_mode,
    output logic                   busy,
    output logic                   done
);
    atlc_state_t            state;
    logic [15:0]            req_ref;
    logic [15:0]            req_mix;
    logic [31:0]            req_freq;
    logic [15:0]            snap_ref;
    logic [15:0]            snap_mix;
    logic signed [17:0]     work_ref;
    logic signed [17:0]     work_mix;
    atlc_warn_t             work_warn;
    logic                   work_auto;
    logic [2:0]             work_rf;
    logic                   low_freq;
    logic [15:0]            lvl_ref;
    logic [15:0]            lvl_mix;
    logic                   accept;
    logic                   freq_wr;
    logic                   freq_low;
    logic signed [17:0]     next_ref;
    logic signed [17:0]     next_mix;
    atlc_warn_t             next_warn;
    logic                   next_auto;
    logic signed [17:0]     rf_diff;
    logic signed [17:0]     if_comp;
    logic [2:0]             rf_idx;
    logic [1:0]             if_idx;
    logic [2:0]             rf_bits;
    logic [ATLC_DW-1:0]     status_word;

    // Apply while busy is dropped, not queued
    // Apply strobe accepted
    assign accept   = reg_wr && (reg_addr == ATLC_OFS_CTRL)
                      && reg_wdata[ATLC_CTRL_APPLY] && (state == ATLC_IDLE);
    assign freq_wr  = reg_wr && (reg_addr == ATLC_OFS_FREQ);
    assign freq_low = reg_wdata < LOWF_KHZ;
    assign busy     = state != ATLC_IDLE;

    // Upper write bits of the levels are dropped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_ref <= ATLC_REF_RST;
        end else if (reg_wr && reg_addr == ATLC_OFS_REF) begin
            req_ref <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_mix <= ATLC_MIX_RST;
        end else if (reg_wr && reg_addr == ATLC_OFS_MIX) begin
            req_mix <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_freq <= ATLC_FREQ_RST;
        end else if (freq_wr) begin
            req_freq <= reg_wdata;
        end
    end

    // Snapshot so writes during processing cannot tear a request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            snap_ref <= ATLC_REF_RST;
        end else if (accept) begin
            snap_ref <= req_ref;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            snap_mix <= ATLC_MIX_RST;
        end else if (accept) begin
            snap_mix <= req_mix;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ATLC_IDLE;
        end else begin
            unique case (state)
                ATLC_IDLE: begin
                    if (accept) begin
                        state <= ATLC_COERCE;
                    end
                end
                ATLC_COERCE: begin
                    state <= ATLC_RF;
                end
                ATLC_RF: begin
                    state <= ATLC_IF;
                end
                ATLC_IF: begin
                    state <= ATLC_IDLE;
                end
            endcase
        end
    end

    // Levels widened to 18 bits so ref minus 50 cannot wrap
    always_comb begin
        next_warn = '0;
        next_ref  = 18'(signed'(snap_ref));
        next_auto = signed'(snap_mix) > ATLC_AUTO_THRESH;
        next_mix  = next_auto ? ATLC_AUTO_MIX : 18'(signed'(snap_mix));
        if (next_mix > ATLC_MIX_MAX) begin
            next_mix = ATLC_MIX_MAX;
            next_warn.mix_above_zero = 1'b1;
        end
        if (next_ref > ATLC_REF_MAX) begin
            next_ref = ATLC_REF_MAX;
            next_warn.ref_range = 1'b1;
        end
        if (next_mix > next_ref) begin
            next_mix = next_ref;
            next_warn.mix_window = 1'b1;
        end else if (next_mix < next_ref - ATLC_WINDOW) begin
            next_mix = next_ref - ATLC_WINDOW;
            next_warn.mix_window = 1'b1;
        end
        if (next_auto) begin
            next_warn.mix_above_zero = 1'b0;
            next_warn.mix_window = 1'b0;
        end
    end

    // Window keeps difference realisable
    // Coerced levels land once so both selectors see one request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            work_ref <= '0;
        end else if (state == ATLC_COERCE) begin
            work_ref <= next_ref;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            work_mix <= '0;
        end else if (state == ATLC_COERCE) begin
            work_mix <= next_mix;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            work_auto <= 1'b0;
        end else if (state == ATLC_COERCE) begin
            work_auto <= next_auto;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            work_warn <= '0;
        end else if (state == ATLC_COERCE) begin
            work_warn <= next_warn;
        end
    end

    assign rf_diff = work_ref - work_mix;
    assign if_comp = ATLC_IF_GAIN + work_mix;

    atlc_step_sel #(
        .W       (ATLC_LW),
        .STEPS   (ATLC_RF_STEPS),
        .STEP_DB (ATLC_STEP_DB),
        .IW      (3)
    ) u_rf_sel (
        .value (rf_diff),
        .idx   (rf_idx)
    );

    // Negative clamps to zero in selector
    atlc_step_sel #(
        .W       (ATLC_LW),
        .STEPS   (ATLC_IF_STEPS),
        .STEP_DB (ATLC_STEP_DB),
        .IW      (2)
    ) u_if_sel (
        .value (if_comp),
        .idx   (if_idx)
    );

    always_comb begin
        unique case (rf_idx)
            3'd0:    rf_bits = 3'b000;
            3'd1:    rf_bits = 3'b001;
            3'd2:    rf_bits = 3'b100;
            3'd3:    rf_bits = 3'b101;
            3'd4:    rf_bits = 3'b110;
            3'd5:    rf_bits = 3'b111;
            default: rf_bits = 3'b111;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            work_rf <= 3'b000;
        end else if (state == ATLC_RF) begin
            work_rf <= rf_bits;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_freq <= 1'b0;
        end else if (freq_wr) begin
            low_freq <= freq_low;
        end
    end

    // Low freq engage bypasses the engine so it acts at once
    // Five stage outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            atten <= '0;
        end else if (state == ATLC_IF) begin
            {atten.rf_20a, atten.rf_20b, atten.rf_10} <= work_rf;
            atten.if_20 <= if_idx[1];
            // Same-cycle frequency write still counts
            // Low frequency forcing
            atten.if_10 <= if_idx[0] | low_freq | (freq_wr && freq_low);
        end else if (freq_wr && freq_low) begin
            atten.if_10 <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            warn <= '0;
        end else if (state == ATLC_IF) begin
            warn <= work_warn;
            warn.if_below_nominal <= (if_comp < 0) && !work_auto;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            automatic_mixer_mode <= 1'b0;
        end else if (state == ATLC_IF) begin
            automatic_mixer_mode <= work_auto;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lvl_ref <= ATLC_REF_RST;
        end else if (state == ATLC_IF) begin
            lvl_ref <= work_ref[15:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lvl_mix <= ATLC_MIX_RST;
        end else if (state == ATLC_IF) begin
            lvl_mix <= work_mix[15:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else begin
            done <= state == ATLC_IF;
        end
    end

    always_comb begin
        status_word                         = '0;
        status_word[ATLC_ST_BUSY]           = busy;
        status_word[ATLC_ST_AUTO]           = automatic_mixer_mode;
        status_word[ATLC_ST_LOWF]           = low_freq;
        status_word[ATLC_ST_ATT_LSB +: 5]   = atten;
        status_word[ATLC_ST_WARN_LSB +: 4]  = warn;
    end

    // Unmapped reads return zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            unique case (reg_addr)
                ATLC_OFS_REF:    reg_rdata[15:0] <= req_ref;
                ATLC_OFS_MIX:    reg_rdata[15:0] <= req_mix;
                ATLC_OFS_FREQ:   reg_rdata <= req_freq;
                ATLC_OFS_STATUS: reg_rdata <= status_word;
                ATLC_OFS_LEVELS: reg_rdata <= {lvl_mix, lvl_ref};
                default:         reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule
`default_nettype wire

// file: tb/atlc_switch_bank.sv
// Purpose: model of the switch bank that the five controls drive.
// Assumes: a control at one engages its stage.
// Notes:   reports inserted dB so the bench can check the sum.
`default_nettype none
module atlc_switch_bank
    import atlc_pkg::*;
(
    input  wire atlc_atten_t atten,
    output logic [6:0]       total_db
);
    timeunit 1ns;
    timeprecision 1ps;
    assign total_db = (atten.rf_20a ? 7'h14 : 7'h00)
        + (atten.rf_20b ? 7'h14 : 7'h00) + (atten.rf_10 ? 7'h0A : 7'h00)
        + (atten.if_20 ? 7'h14 : 7'h00) + (atten.if_10 ? 7'h0A : 7'h00);
endmodule
`default_nettype wire

// file: tb/atlc_level_ctrl_checker.sv
// Purpose: port assertions for the level control.
// Assumes: one clock, asynchronous active-low reset.
// Notes:   sees top ports only; bound at the foot.
`default_nettype none
module atlc_level_ctrl_checker
    import atlc_pkg::*;
#(
    parameter logic [31:0] LOWF_KHZ = ATLC_LOWF_KHZ
) (
    input wire logic               clk_sys,
    input wire logic               rst_n,
    input wire logic [ATLC_AW-1:0] reg_addr,
    input wire logic [ATLC_DW-1:0] reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [ATLC_DW-1:0] reg_rdata,
    input wire atlc_atten_t        atten,
    input wire atlc_warn_t         warn,
    input wire logic               automatic_mixer_mode,
    input wire logic               busy,
    input wire logic               done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic apply_req;
    logic low_wr;
    assign apply_req = reg_wr && reg_addr == ATLC_OFS_CTRL && reg_wdata[0];
    assign low_wr = reg_wr && reg_addr == ATLC_OFS_FREQ
        && reg_wdata < LOWF_KHZ;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_APPLY_SEQ: assert property (apply_req && !busy |=>
        busy [*3] ##1 (done && !busy)) else $error("apply sequence wrong");
    AST_DONE_ONE: assert property (done |=> !done)
        else $error("done longer than one cycle");
    AST_WARN_HOLD: assert property (!done |-> $stable(warn))
        else $error("warnings moved outside commit");
    AST_LOWF: assert property (low_wr |=> atten.if_10)
        else $error("low frequency did not engage IF 10 dB");
    AST_AUTO_WARN: assert property (automatic_mixer_mode |->
        !warn.mix_above_zero && !warn.mix_window
        && !warn.if_below_nominal)
        else $error("mixer warning in automatic mode");
    AST_RF_LEGAL: assert property (atten.rf_20b |-> atten.rf_20a)
        else $error("second RF 20 dB without first");
    AST_IF_NEG: assert property (warn.if_below_nominal |->
        !atten.if_20) else $error("IF 20 dB with negative compensation");
    AST_STATUS_RD: assert property (reg_rd
        && reg_addr == ATLC_OFS_STATUS |=> reg_rdata[7:3] == $past(atten)
        && reg_rdata[11:8] == $past(warn)) else $error("status read wrong");
    cover property (apply_req && !busy);
    cover property (done && automatic_mixer_mode);
    cover property (done && warn.if_below_nominal);
endmodule
bind atlc_level_ctrl atlc_level_ctrl_checker #(.LOWF_KHZ(LOWF_KHZ))
    atlc_level_ctrl_checker_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .atten(atten), .warn(warn),
    .automatic_mixer_mode(automatic_mixer_mode), .busy(busy), .done(done));
`default_nettype wire

// file: tb/atlc_level_ctrl_tb.sv
// Purpose: self-checking bench for the level control.
// Assumes: strobes change by nonblocking assignment after rising edges.
// Notes:   table rows first, then low frequency, busy, registers, reset.
`default_nettype none
module atlc_level_ctrl_tb
    import atlc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [15:0] r;
        logic [15:0] m;
        logic [4:0]  a;
        logic [3:0]  w;
        logic        au;
        logic [6:0]  db;
    } atlc_row_t;
    logic        clk_sys   = 1'b0;
    logic        rst_n     = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    atlc_atten_t atten;
    atlc_warn_t  warn;
    logic        auto_mode;
    logic        busy;
    logic        done;
    logic [6:0]  total_db;
    int          num_errors = 0;
    int          n_tests    = 0;
    // Levels in dBm, low 16 bits; ties round upward
    atlc_row_t rows [11] = '{
        '{16'h0000, 16'hFFEC, 5'h11, 4'h0, 1'b0, 7'h1E},
        '{16'h000A, 16'h0005, 5'h07, 4'h8, 1'b0, 7'h28},
        '{16'h003C, 16'hFFF6, 5'h1F, 4'h6, 1'b0, 7'h50},
        '{16'hFFF6, 16'h0000, 5'h02, 4'h2, 1'b0, 7'h14},
        '{16'hFFEC, 16'hFFC4, 5'h18, 4'h1, 1'b0, 7'h28},
        '{16'h0000, 16'h07D0, 5'h11, 4'h0, 1'b1, 7'h1E},
        '{16'h0046, 16'h07D0, 5'h1F, 4'h4, 1'b1, 7'h50},
        '{16'h0000, 16'hFFE7, 5'h15, 4'h0, 1'b0, 7'h28},
        '{16'h0000, 16'hFFDD, 5'h18, 4'h1, 1'b0, 7'h28},
        '{16'h000A, 16'h03E8, 5'h07, 4'h8, 1'b0, 7'h28},
        '{16'hFFD8, 16'h07D0, 5'h00, 4'h0, 1'b1, 7'h00}};
    always #2 clk_sys = ~clk_sys;
    atlc_level_ctrl atlc_level_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .atten(atten),
        .warn(warn), .automatic_mixer_mode(auto_mode), .busy(busy),
        .done(done));
    atlc_switch_bank atlc_switch_bank_i (.atten(atten), .total_db(total_db));
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Bounded wait so a stuck engine ends the run
    task automatic apply();
        int k;
        wr(ATLC_OFS_CTRL, 32'h0000_0001);
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys);
            #1;
            if (done === 1'b1) break;
        end
        if (k == 20) begin
            num_errors++;
            summarize();
        end
    endtask
    initial begin
        logic [31:0] d;
        int          n;
        atlc_row_t   r;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        wr(ATLC_OFS_FREQ, 32'h0000_3A98);
        for (int i = 0; i < 11; i++) begin
            r = rows[i];
            wr(ATLC_OFS_REF, {16'h0000, r.r});
            wr(ATLC_OFS_MIX, {16'h0000, r.m});
            apply();
            chk("atten", 32'(atten), 32'(r.a));
            chk("warn", 32'(warn), 32'(r.w));
            chk("auto", 32'(auto_mode), 32'(r.au));
            chk("db", 32'(total_db), 32'(r.db));
            $display("row %0d finished", i);
        end
        wr(ATLC_OFS_REF, 32'h0000_FFF6);
        wr(ATLC_OFS_MIX, 32'h0000_0000);
        apply();
        wr(ATLC_OFS_FREQ, 32'h0000_3A97);
        #1;
        chk("lowf atten", 32'(atten), 32'h0000_0003);
        rd(ATLC_OFS_STATUS, d);
        chk("lowf flag", 32'(d[ATLC_ST_LOWF]), 32'h0000_0001);
        apply();
        chk("lowf kept", 32'(atten), 32'h0000_0003);
        wr(ATLC_OFS_FREQ, 32'h0000_3A98);
        apply();
        chk("lowf off", 32'(atten), 32'h0000_0002);
        $display("low frequency test finished");
        wr(ATLC_OFS_CTRL, 32'h0000_0001);
        wr(ATLC_OFS_CTRL, 32'h0000_0001);
        n = 0;
        repeat (10) begin
            @(posedge clk_sys);
            #1;
            n += 32'(done);
        end
        chk("done count", 32'(n), 32'h0000_0001);
        $display("busy refusal test finished");
        rd(ATLC_OFS_LEVELS, d);
        chk("levels", d, 32'hFFF6_FFF6);
        wr(ATLC_OFS_STATUS, 32'hFFFF_FFFF);
        rd(ATLC_OFS_STATUS, d);
        chk("status", d, 32'h0000_0210);
        wr(ATLC_OFS_REF, 32'h1234_FFEC);
        rd(ATLC_OFS_REF, d);
        chk("ref", d, 32'h0000_FFEC);
        rd(ATLC_OFS_CTRL, d);
        chk("ctrl", d, 32'h0000_0000);
        rd(8'h20, d);
        chk("unmapped", d, 32'h0000_0000);
        $display("register test finished");
        @(posedge clk_sys);
        rst_n <= 1'b0;
        #1;
        chk("rst atten", 32'(atten), 32'h0000_0000);
        chk("rst warn", 32'(warn), 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ATLC_OFS_REF, d);
        chk("rst ref", d, {16'h0000, ATLC_REF_RST});
        $display("reset test finished");
        summarize();
    end
endmodule
`default_nettype wire
